// file: rtl/ppm_pin_mux.sv
// Peripheral pin multiplexer for ports 0, 1 and 2.
`timescale 1ns/1ps

// Functional notes
// - A peripheral other than I2S drives and samples a pin only when its select bit is 1.
// - Every multiplexed peripheral has two pin sets, chosen by one location bit.
// - Serial zero uses P0_5..P0_2 or P1_5..P1_2 in the mapped signal order.
// - Serial one uses P0_5..P0_2 or P1_7..P1_4 in the mapped signal order.
// - Timer one channels 2,1,0 on P0_4..P0_2, or 0,1,2 on P1_2..P1_0.
// - Timer three channels 1,0 on P1_4,P1_3 or P1_7,P1_6.
// - Timer four channels 1,0 on P1_1,P1_0 or P2_3,P2_0.
// - I2S clock, word select, receive, transmit on P0_1,P0_0,P1_7,P1_6 or P2_3..P2_0.
// - Fixed: analog inputs on port 0, crystal on P2_4/P2_3, debug on P2_2/P2_1.
// - Port 0 field 00 favours serial zero, 01 favours serial one.
// - Port 0 field 10 or 11: timer one beats both serial units; 10 favours serial one, 11 serial zero.
// - Serial zero UART without flow control frees P0_4 and P0_5.
// - Serial one UART without flow control frees P0_3 and P0_2.
// - Port 1 bits 3 and 0 both clear: serial zero wins its pins.
// - Freed serial zero pins still go to serial one and timer one.
// - Port 1 bit 3 set, bit 2 clear: serial one beats serial zero, timer three.
// - Port 1 bit 1 clear, bit 0 set: timer one beats timer four, serial zero.
// - Port 1 bit 2 set: timer three beats serial one.
// - Port 1 bit 1 set: timer four beats timer one.
// - Location bit 0 selects alternative 1, 1 selects alternative 2.
// - Select bit n of port 0 governs P0_n: 0 GPIO, 1 peripheral.
// - An enabled I2S unit takes its pins over all but debug and crystal, select ignored.
module ppm_pin_mux (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Settings
    input wire ppm_pkg::ppm_cfg_t cfg,
    // Pads
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pad_in,
    output logic [ppm_pkg::PIN_COUNT-1:0] pad_out,
    output logic [ppm_pkg::PIN_COUNT-1:0] pad_oe,
    output logic [ppm_pkg::PIN_COUNT-1:0] pad_analog,
    // General purpose I/O logic
    input wire logic [ppm_pkg::PIN_COUNT-1:0] gpio_out,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] gpio_oe,
    output logic [ppm_pkg::PIN_COUNT-1:0] gpio_in,
    // Peripheral drives and inputs, indexed by peripheral
    input wire ppm_pkg::ppm_drive_t [ppm_pkg::PERIPH_COUNT-1:0] periph_drive,
    output logic [ppm_pkg::PERIPH_COUNT-1:0][ppm_pkg::SLOT_COUNT-1:0] periph_in,
    // Debug interface
    input wire logic debug_data_out,
    input wire logic debug_data_oe,
    output logic debug_data_pin,
    output logic debug_clock_pin,
    // Status
    output ppm_pkg::ppm_owner_t [ppm_pkg::PIN_COUNT-1:0] pin_owner
);
    import ppm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic alt_sel(input ppm_cfg_t c, input int p);
        logic sel;
        sel = 1'b0;
        case (p)
            0: sel = c.serial_zero_location_bit;
            1: sel = c.serial_one_location_bit;
            2: sel = c.timer_one_location_bit;
            3: sel = c.timer_three_location_bit;
            4: sel = c.timer_four_location_bit;
            default: sel = c.i2s_location_bit;
        endcase
        return sel;
    endfunction : alt_sel

    // True when peripheral a wins against peripheral b on a shared pin.
    function automatic logic beats(input ppm_cfg_t c, input logic on_p0, input int a, input int b);
        logic u1_u0;
        logic t1_u0;
        logic t1_u1;
        logic t3_u0;
        logic t3_u1;
        logic t4_t1;
        logic res;
        if (on_p0) begin
            u1_u0 = (c.port0_priority_field == 2'h1) || (c.port0_priority_field == 2'h2);
            t1_u0 = c.port0_priority_field[1];
            t1_u1 = c.port0_priority_field[1];
            t3_u0 = 1'b0;
            t3_u1 = 1'b0;
            t4_t1 = 1'b0;
        end else begin
            u1_u0 = c.port1_priority_bit3;
            t1_u0 = c.port1_priority_bit0;
            t1_u1 = 1'b0;
            t3_u0 = c.port1_priority_bit3 & c.port1_priority_bit2;
            t3_u1 = c.port1_priority_bit2;
            t4_t1 = c.port1_priority_bit1;
        end
        res = 1'b0;
        case ({a[2:0], b[2:0]})
            {PER_U0, PER_U1}: res = !u1_u0;
            {PER_U1, PER_U0}: res = u1_u0;
            {PER_U0, PER_T1}: res = !t1_u0;
            {PER_T1, PER_U0}: res = t1_u0;
            {PER_U1, PER_T1}: res = !t1_u1;
            {PER_T1, PER_U1}: res = t1_u1;
            {PER_U0, PER_T3}: res = !t3_u0;
            {PER_T3, PER_U0}: res = t3_u0;
            {PER_U1, PER_T3}: res = !t3_u1;
            {PER_T3, PER_U1}: res = t3_u1;
            {PER_T1, PER_T4}: res = !t4_t1;
            {PER_T4, PER_T1}: res = t4_t1;
            default: res = 1'b0;
        endcase
        return res;
    endfunction : beats

    ////////////////////////////////////////////////////////////////////////////
    // Settings and pad sampling

    ppm_cfg_t cfg_r;
    logic [PIN_COUNT-1:0] pin_sync;

    // Settings are caught once per clock so that every decision in a cycle
    // sees one coherent set.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_r <= CFG_RESET;
        end else begin
            cfg_r <= cfg;
        end
    end

    ppm_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .async_in(pad_in),
        .sync_out(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Slot placement

    logic [4:0] slot_pin [PERIPH_COUNT][SLOT_COUNT];
    logic [3:0] slot_act [PERIPH_COUNT];

    always_comb begin
        for (int p = 0; p < PERIPH_COUNT; p++) begin
            for (int s = 0; s < SLOT_COUNT; s++) begin
                slot_pin[p][s] = PIN_MAP[p][alt_sel(cfg_r, p)][s*5 +: 5];
            end
            slot_act[p] = SLOT_USED[p];
        end
        if (cfg_r.serial_zero_uart_mode && !cfg_r.serial_zero_flow_enable) begin
            slot_act[PER_U0] = SLOT_USED[PER_U0] & ~FLOW_SLOTS;
        end
        if (cfg_r.serial_one_uart_mode && !cfg_r.serial_one_flow_enable) begin
            slot_act[PER_U1] = SLOT_USED[PER_U1] & ~FLOW_SLOTS;
        end
        if (!cfg_r.i2s_unit_enable) begin
            slot_act[PER_I2S] = 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Claims and candidate drives per pin

    logic [PERIPH_COUNT-1:0] claim [PIN_COUNT];
    logic [PERIPH_COUNT-1:0] cand_out [PIN_COUNT];
    logic [PERIPH_COUNT-1:0] cand_oe [PIN_COUNT];

    always_comb begin
        for (int n = 0; n < PIN_COUNT; n++) begin
            claim[n] = '0;
            cand_out[n] = '0;
            cand_oe[n] = '0;
        end
        for (int p = 0; p < PERIPH_COUNT; p++) begin
            for (int s = 0; s < SLOT_COUNT; s++) begin
                if (slot_act[p][s]) begin
                    claim[slot_pin[p][s]][p] = 1'b1;
                    cand_out[slot_pin[p][s]][p] = periph_drive[p].out[s];
                    cand_oe[slot_pin[p][s]][p] = periph_drive[p].oe[s];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ownership

    ppm_owner_t owner_nxt [PIN_COUNT];

    // Debug and crystal come first, then the I2S unit, then the analog inputs, then
    // the select bit, then the priority settings. A pin whose claimants beat one another in a
    // circle is left to nobody rather than to an arbitrary winner.
    always_comb begin
        logic found;
        logic beaten;
        logic on_p0;
        found = 1'b0;
        beaten = 1'b0;
        on_p0 = 1'b0;
        for (int n = 0; n < PIN_COUNT; n++) begin
            on_p0 = (n < P0_WIDTH);
            owner_nxt[n] = OWN_NONE;
            if (cfg_r.debug_active && (n == int'(PIN_DBG_DATA) || n == int'(PIN_DBG_CLK))) begin
                owner_nxt[n] = OWN_DBG;
            end else if (cfg_r.xosc_active && (n == int'(PIN_XOSC_ONE) || n == int'(PIN_XOSC_TWO))) begin
                owner_nxt[n] = OWN_XOSC;
            end else if (claim[n][PER_I2S]) begin
                owner_nxt[n] = OWN_I2S;
            end else if (on_p0 && cfg_r.adc_input_enable[n%P0_WIDTH]) begin
                owner_nxt[n] = OWN_ADC;
            end else if (!cfg_r.port_function_select[n]) begin
                owner_nxt[n] = OWN_GPIO;
            end else begin
                found = 1'b0;
                for (int a = 0; a < PERIPH_COUNT - 1; a++) begin
                    beaten = 1'b0;
                    for (int b = 0; b < PERIPH_COUNT - 1; b++) begin
                        if (b != a && claim[n][b] && beats(cfg_r, on_p0, b, a)) begin
                            beaten = 1'b1;
                        end
                    end
                    if (!found && claim[n][a] && !beaten) begin
                        found = 1'b1;
                        owner_nxt[n] = ppm_owner_t'(11'h004 << a);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pad output stages

    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        ppm_pin_slice u_slice (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .owner(owner_nxt[g]),
            .gpio_out(gpio_out[g]),
            .gpio_oe(gpio_oe[g]),
            .per_out(cand_out[g]),
            .per_oe(cand_oe[g]),
            .dbg_out((g == int'(PIN_DBG_DATA)) ? debug_data_out : 1'b0),
            .dbg_oe((g == int'(PIN_DBG_DATA)) ? debug_data_oe : 1'b0),
            .pad_out(pad_out[g]),
            .pad_oe(pad_oe[g]),
            .pad_analog(pad_analog[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input routing

    logic [SLOT_COUNT-1:0] per_in_nxt [PERIPH_COUNT];

    // A slot sees its pin only while its peripheral owns that pin; otherwise
    // it is held at its idle level so a losing receiver stays quiet.
    always_comb begin
        for (int p = 0; p < PERIPH_COUNT; p++) begin
            for (int s = 0; s < SLOT_COUNT; s++) begin
                per_in_nxt[p][s] = IN_IDLE[p][s];
                if (slot_act[p][s] && owner_nxt[slot_pin[p][s]] == ppm_owner_t'(11'h004 << p)) begin
                    per_in_nxt[p][s] = pin_sync[slot_pin[p][s]];
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < PERIPH_COUNT; p++) begin
                periph_in[p] <= IN_IDLE[p];
            end
        end else begin
            for (int p = 0; p < PERIPH_COUNT; p++) begin
                periph_in[p] <= per_in_nxt[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General purpose inputs, debug inputs and status

    // Port reads return the pin level whatever the pin is assigned to.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gpio_in <= '0;
        end else begin
            gpio_in <= pin_sync;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            debug_data_pin <= 1'b0;
            debug_clock_pin <= 1'b0;
        end else begin
            debug_data_pin <= cfg_r.debug_active & pin_sync[PIN_DBG_DATA];
            debug_clock_pin <= cfg_r.debug_active & pin_sync[PIN_DBG_CLK];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int n = 0; n < PIN_COUNT; n++) begin
                pin_owner[n] <= OWN_NONE;
            end
        end else begin
            for (int n = 0; n < PIN_COUNT; n++) begin
                pin_owner[n] <= owner_nxt[n];
            end
        end
    end

endmodule : ppm_pin_mux

// file: rtl/ppm_pkg.sv
// Constants, pin maps and carrier types of the peripheral pin multiplexer.
package ppm_pkg;

    localparam int PIN_COUNT = 21;
    localparam int PERIPH_COUNT = 6;
    localparam int SLOT_COUNT = 4;
    localparam int P0_WIDTH = 8;

    // Peripheral indices into the drive and input arrays.
    localparam logic [2:0] PER_U0 = 3'h0;
    localparam logic [2:0] PER_U1 = 3'h1;
    localparam logic [2:0] PER_T1 = 3'h2;
    localparam logic [2:0] PER_T3 = 3'h3;
    localparam logic [2:0] PER_T4 = 3'h4;
    localparam logic [2:0] PER_I2S = 3'h5;

    // Global pin index: P0_n is n, P1_n is 8+n, P2_n is 16+n.
    localparam logic [4:0] PIN_DBG_DATA = 5'h11;
    localparam logic [4:0] PIN_DBG_CLK = 5'h12;
    localparam logic [4:0] PIN_XOSC_ONE = 5'h13;
    localparam logic [4:0] PIN_XOSC_TWO = 5'h14;

    // Serial slots: 0 SCK/RTS, 1 SSN/CTS, 2 MOSI/TX, 3 MISO/RX.
    // Timer slots: compare channel number. I2S slots: 0 CK, 1 WS, 2 RX, 3 TX.
    // Each entry packs slot 3 down to slot 0, index 0 is alternative 1.
    localparam logic [19:0] PIN_MAP [PERIPH_COUNT][2] = '{
        '{{5'h02, 5'h03, 5'h04, 5'h05}, {5'h0c, 5'h0d, 5'h0a, 5'h0b}},
        '{{5'h05, 5'h04, 5'h02, 5'h03}, {5'h0f, 5'h0e, 5'h0c, 5'h0d}},
        '{{5'h00, 5'h04, 5'h03, 5'h02}, {5'h00, 5'h08, 5'h09, 5'h0a}},
        '{{5'h00, 5'h00, 5'h0c, 5'h0b}, {5'h00, 5'h00, 5'h0f, 5'h0e}},
        '{{5'h00, 5'h00, 5'h09, 5'h08}, {5'h00, 5'h00, 5'h13, 5'h10}},
        '{{5'h0e, 5'h0f, 5'h00, 5'h01}, {5'h10, 5'h11, 5'h12, 5'h13}}
    };
    localparam logic [3:0] SLOT_USED [PERIPH_COUNT] = '{4'hf, 4'hf, 4'h7, 4'h3, 4'h3, 4'hf};
    // RTS and CTS slots, given up in UART mode without flow control.
    localparam logic [3:0] FLOW_SLOTS = 4'h3;
    // Level a peripheral sees on an input it does not own: SSN/CTS and MISO/RX idle high.
    localparam logic [3:0] IN_IDLE [PERIPH_COUNT] = '{4'ha, 4'ha, 4'h0, 4'h0, 4'h0, 4'h0};

    typedef struct packed {
        logic [20:0] port_function_select;
        logic serial_zero_location_bit;
        logic serial_one_location_bit;
        logic timer_one_location_bit;
        logic timer_three_location_bit;
        logic timer_four_location_bit;
        logic i2s_location_bit;
        logic [1:0] port0_priority_field;
        logic port1_priority_bit3;
        logic port1_priority_bit2;
        logic port1_priority_bit1;
        logic port1_priority_bit0;
        logic i2s_unit_enable;
        logic [7:0] adc_input_enable;
        logic debug_active;
        logic xosc_active;
        logic serial_zero_uart_mode;
        logic serial_zero_flow_enable;
        logic serial_one_uart_mode;
        logic serial_one_flow_enable;
    } ppm_cfg_t;

    localparam ppm_cfg_t CFG_RESET = '0;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } ppm_drive_t;

    typedef enum logic [10:0] {
        OWN_NONE = 11'h001,
        OWN_GPIO = 11'h002,
        OWN_U0 = 11'h004,
        OWN_U1 = 11'h008,
        OWN_T1 = 11'h010,
        OWN_T3 = 11'h020,
        OWN_T4 = 11'h040,
        OWN_I2S = 11'h080,
        OWN_DBG = 11'h100,
        OWN_XOSC = 11'h200,
        OWN_ADC = 11'h400
    } ppm_owner_t;

endpackage : ppm_pkg

// file: rtl/ppm_sync.sv
// Two-stage synchroniser for the pad inputs.
`timescale 1ns/1ps
module ppm_sync #(
    parameter int WIDTH = 21
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_out <= '0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule : ppm_sync

// file: rtl/ppm_pin_slice.sv
// Output stage of one pad: picks the owner's drive and registers it.
`timescale 1ns/1ps
module ppm_pin_slice (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Selection
    input wire ppm_pkg::ppm_owner_t owner,
    // Candidate drives
    input wire logic gpio_out,
    input wire logic gpio_oe,
    input wire logic [5:0] per_out,
    input wire logic [5:0] per_oe,
    input wire logic dbg_out,
    input wire logic dbg_oe,
    // Pad
    output logic pad_out,
    output logic pad_oe,
    output logic pad_analog
);
    import ppm_pkg::*;

    logic out_nxt;
    logic oe_nxt;
    logic analog_nxt;

    always_comb begin
        out_nxt = 1'b0;
        oe_nxt = 1'b0;
        analog_nxt = 1'b0;
        unique case (owner)
            OWN_NONE: begin
            end
            OWN_GPIO: begin
                out_nxt = gpio_out;
                oe_nxt = gpio_oe;
            end
            OWN_U0, OWN_U1, OWN_T1, OWN_T3, OWN_T4, OWN_I2S: begin
                out_nxt = |(per_out & owner[7:2]);
                oe_nxt = |(per_oe & owner[7:2]);
            end
            OWN_DBG: begin
                out_nxt = dbg_out;
                oe_nxt = dbg_oe;
            end
            OWN_XOSC, OWN_ADC: begin
                analog_nxt = 1'b1;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            pad_analog <= 1'b0;
        end else begin
            pad_out <= out_nxt;
            pad_oe <= oe_nxt;
            pad_analog <= analog_nxt;
        end
    end

endmodule : ppm_pin_slice

// file: tb/ppm_pin_mux_props.sv
// Port assertions for the peripheral pin multiplexer.
`timescale 1ns/1ps
module ppm_pin_mux_props (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Watched ports
    input wire ppm_pkg::ppm_cfg_t cfg,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pad_in,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pad_out,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pad_oe,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pad_analog,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] gpio_out,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] gpio_oe,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] gpio_in,
    input wire ppm_pkg::ppm_drive_t [ppm_pkg::PERIPH_COUNT-1:0] periph_drive,
    input wire logic [ppm_pkg::PERIPH_COUNT-1:0][ppm_pkg::SLOT_COUNT-1:0] periph_in,
    input wire ppm_pkg::ppm_owner_t [ppm_pkg::PIN_COUNT-1:0] pin_owner
);
    import ppm_pkg::*;
    logic [PIN_COUNT-1:0] gp_v;
    logic [PIN_COUNT-1:0] none_v;
    logic [PIN_COUNT-1:0] ana_v;
    logic [2:0] age_r;
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            gp_v[i] = pin_owner[i] == OWN_GPIO;
            none_v[i] = pin_owner[i] == OWN_NONE;
            ana_v[i] = pin_owner[i] == OWN_ADC || pin_owner[i] == OWN_XOSC;
        end
    end
    // Edges since reset release; the guard keeps $past from looking back into reset.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            age_r <= 3'h0;
        end else if (age_r != 3'h4) begin
            age_r <= age_r + 3'h1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_reset_all_gpio: assert property (age_r == 3'h1 |-> &gp_v) else $error("pins not GPIO after reset");
    a_gpio_drive_path: assert property (((gp_v & $past(gp_v)) & ((pad_out ^ $past(gpio_out))
        | (pad_oe ^ $past(gpio_oe)))) == '0) else $error("GPIO drive lost");
    a_gpio_in_live: assert property (age_r == 3'h4 |-> gpio_in == $past(pad_in, 3)) else $error("gpio_in lag");
    a_owner_drives: assert property (pin_owner[5] == OWN_U0 && $past(pin_owner[5]) == OWN_U0
        |-> pad_out[5] == $past(periph_drive[0].out[0]) && pad_oe[5] == $past(periph_drive[0].oe[0]))
        else $error("serial zero clock not on pad");
    a_loser_idle: assert property (age_r == 3'h4 && !$past(cfg.serial_one_location_bit, 2)
        && pin_owner[2] != OWN_U1 |-> periph_in[1][1]) else $error("loser sees pin");
    a_none_quiet: assert property ((none_v & pad_oe) == '0) else $error("unowned pin driven");
    a_analog_map: assert property (pad_analog == ana_v) else $error("analog mode mismatch");
    a_i2s_first: assert property (age_r == 3'h4 && $past(cfg.i2s_unit_enable, 2)
        && !$past(cfg.i2s_location_bit, 2) |-> pin_owner[1] == OWN_I2S) else $error("I2S lost pin");
    a_select_off: assert property (age_r == 3'h4 && !$past(cfg.port_function_select[3], 2)
        && !$past(cfg.adc_input_enable[3], 2) |-> pin_owner[3] == OWN_GPIO) else $error("select ignored");
endmodule : ppm_pin_mux_props
bind ppm_pin_mux ppm_pin_mux_props u_props (.clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_analog(pad_analog), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_in(gpio_in), .periph_drive(periph_drive), .periph_in(periph_in),
    .pin_owner(pin_owner));

// file: tb/ppm_pad_partner.sv
// External devices on the pads: echo a driven pad, else force a fresh level.
`timescale 1ns/1ps
module ppm_pad_partner (
    // Pads
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pad_out,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] pad_oe,
    input wire logic [ppm_pkg::PIN_COUNT-1:0] ext_level,
    output logic [ppm_pkg::PIN_COUNT-1:0] pad_in
);
    // A released pad never keeps its last value; the bench changes ext_level every case.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : ppm_pad_partner

// file: tb/test_ppm_pin_mux.sv
// Self-checking bench for the peripheral pin multiplexer.
`timescale 1ns/1ps
module test_ppm_pin_mux;
    import ppm_pkg::*;
    typedef struct {
        logic [4:0] pin;
        ppm_owner_t ow;
        logic [2:0] per;
        logic [1:0] sl;
        logic eo;
        logic eoe;
    } ppm_exp_t;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    ppm_cfg_t cfg = CFG_RESET;
    logic [PIN_COUNT-1:0] pad_in, pad_out, pad_oe, pad_analog, gpio_in;
    logic [PIN_COUNT-1:0] gpio_out = '0, gpio_oe = '0, ext_level = '0;
    ppm_drive_t [PERIPH_COUNT-1:0] periph_drive = '0;
    logic [PERIPH_COUNT-1:0][SLOT_COUNT-1:0] periph_in;
    logic debug_data_out = 1'b0, debug_data_oe = 1'b0, debug_data_pin, debug_clock_pin;
    ppm_owner_t [PIN_COUNT-1:0] pin_owner;
    logic [31:0] seed = 32'h62b6;
    int fails = 0, checks_done = 0;
    ppm_exp_t q[$];
    ppm_exp_t m_e;
    event chk_ev;
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    ppm_pin_mux u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfg(cfg), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad_analog(pad_analog), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
        .periph_drive(periph_drive), .periph_in(periph_in), .debug_data_out(debug_data_out),
        .debug_data_oe(debug_data_oe), .debug_data_pin(debug_data_pin), .debug_clock_pin(debug_clock_pin),
        .pin_owner(pin_owner));
    ppm_pad_partner u_far (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in));
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        end
        return seed;
    endfunction : rnd
    task automatic cmp(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            fails++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : cmp
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    // Apply settings with random drives, let both paths settle, then note the expected pad.
    task automatic tc(input logic [47:0] c, input logic [4:0] pin, input ppm_owner_t ow, input logic [2:0] per,
        input logic [1:0] sl);
        ppm_exp_t e;
        logic [31:0] r2, r3;
        @(posedge clk_sys);
        #1;
        cfg = ppm_cfg_t'(c);
        r2 = rnd();
        r3 = rnd();
        periph_drive = {r2, r3[15:0]};
        gpio_out = r3[31:11];
        r2 = rnd();
        r3 = rnd();
        gpio_oe = r2[20:0];
        ext_level = r3[20:0];
        debug_data_out = r2[31];
        debug_data_oe = r2[30];
        repeat (5) @(posedge clk_sys);
        #2;
        e.pin = pin;
        e.ow = ow;
        e.per = per;
        e.sl = sl;
        e.eo = per < 3'h6 ? periph_drive[per].out[sl] : gpio_out[pin] & (ow == OWN_GPIO);
        e.eoe = per < 3'h6 ? periph_drive[per].oe[sl] : gpio_oe[pin] & (ow == OWN_GPIO);
        q.push_back(e);
        -> chk_ev;
    endtask : tc
    always @(chk_ev) begin
        m_e = q.pop_front();
        cmp(pin_owner[m_e.pin] === m_e.ow, "pin owner");
        cmp(gpio_in[m_e.pin] === pad_in[m_e.pin], "gpio input");
        if (m_e.ow == OWN_DBG) begin
            cmp(debug_clock_pin === pad_in[PIN_DBG_CLK], "debug clock");
            cmp(debug_data_pin === pad_in[PIN_DBG_DATA], "debug data in");
            cmp(pad_out[PIN_DBG_DATA] === debug_data_out && pad_oe[PIN_DBG_DATA] === debug_data_oe, "debug drive");
        end else if (m_e.per == 3'h7) begin
            cmp(pad_analog[m_e.pin] === 1'b1, "analog mode");
        end else begin
            cmp(pad_out[m_e.pin] === m_e.eo && pad_oe[m_e.pin] === m_e.eoe, "pad drive");
        end
        if (m_e.per < 3'h6) begin
            cmp(periph_in[m_e.per][m_e.sl] === pad_in[m_e.pin], "peripheral input");
        end
    end
    initial begin
        repeat (2000) @(posedge clk_sys);
        fails++;
        results();
    end
    // Up to three claimants on port 0, flowless UART on both ports.
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        tc({21'h00003c, 12'h000, 15'h0000}, 5'h05, OWN_U0, 3'h0, 2'h0);
        tc({21'h000008, 12'h030, 15'h0000}, 5'h02, OWN_GPIO, 3'h6, 2'h0);
        tc({21'h000008, 12'h030, 15'h0000}, 5'h03, OWN_T1, 3'h2, 2'h1);
        tc({21'h003c00, 12'h800, 15'h0000}, 5'h0a, OWN_U0, 3'h0, 2'h1);
        tc({21'h00f000, 12'h400, 15'h0000}, 5'h0f, OWN_U1, 3'h1, 2'h3);
        tc({21'h000700, 12'h200, 15'h0000}, 5'h08, OWN_T1, 3'h2, 2'h2);
        tc({21'h00c000, 12'h100, 15'h0000}, 5'h0e, OWN_T3, 3'h3, 2'h0);
        tc({21'h090000, 12'h080, 15'h0000}, 5'h13, OWN_T4, 3'h4, 2'h1);
        tc({21'h000000, 12'h000, 15'h4000}, 5'h01, OWN_I2S, 3'h5, 2'h0);
        tc({21'h00f000, 12'h400, 15'h4000}, 5'h0f, OWN_I2S, 3'h5, 2'h2);
        tc({21'h000000, 12'h040, 15'h4000}, 5'h10, OWN_I2S, 3'h5, 2'h3);
        tc({21'h000000, 12'h040, 15'h4020}, 5'h12, OWN_DBG, 3'h7, 2'h0);
        tc({21'h000010, 12'h000, 15'h0400}, 5'h04, OWN_ADC, 3'h7, 2'h0);
        tc({21'h000000, 12'h000, 15'h0010}, 5'h14, OWN_XOSC, 3'h7, 2'h0);
        tc({21'h00003c, 12'h000, 15'h0000}, 5'h02, OWN_U0, 3'h0, 2'h3);
        tc({21'h00003c, 12'h010, 15'h0000}, 5'h02, OWN_U1, 3'h1, 2'h1);
        tc({21'h00003c, 12'h020, 15'h0000}, 5'h03, OWN_T1, 3'h2, 2'h1);
        tc({21'h00003c, 12'h030, 15'h0000}, 5'h04, OWN_T1, 3'h2, 2'h2);
        tc({21'h00003c, 12'h000, 15'h0008}, 5'h05, OWN_U1, 3'h1, 2'h3);
        tc({21'h00003c, 12'h000, 15'h000c}, 5'h05, OWN_U0, 3'h0, 2'h0);
        tc({21'h000001, 12'h000, 15'h0000}, 5'h00, OWN_NONE, 3'h6, 2'h0);
        tc({21'h00003c, 12'h010, 15'h0002}, 5'h02, OWN_U0, 3'h0, 2'h3);
        tc({21'h003f00, 12'ha00, 15'h0000}, 5'h0a, OWN_U0, 3'h0, 2'h1);
        tc({21'h003f00, 12'ha01, 15'h0000}, 5'h0a, OWN_T1, 3'h2, 2'h0);
        tc({21'h003f00, 12'ha00, 15'h0008}, 5'h0a, OWN_T1, 3'h2, 2'h0);
        tc({21'h00fc00, 12'hc08, 15'h0000}, 5'h0c, OWN_U1, 3'h1, 2'h1);
        tc({21'h00f800, 12'h404, 15'h0000}, 5'h0c, OWN_T3, 3'h3, 2'h1);
        tc({21'h000700, 12'h202, 15'h0000}, 5'h08, OWN_T4, 3'h4, 2'h0);
        @(posedge clk_sys);
        #1;
        cfg = ppm_cfg_t'({21'h000000, 12'h000, 15'h3fc0});
        reset_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        tc({21'h000000, 12'h000, 15'h3fc0}, 5'h00, OWN_ADC, 3'h7, 2'h0);
        @(posedge clk_sys);
        results();
    end
endmodule : test_ppm_pin_mux
